// ---- hdl/rgefc_ctrl.sv ----
// Enable, soft-start, phase strap, power-ok and overvoltage crowbar control.
// What this block does
// - Run once supply detect rises; shut down when it falls.
// - Threshold enable above its on level allows activity, with other permits.
// - Threshold enable below fault reset level clears faults, rearms soft-start.
// - Activity needs logic enable, threshold enable, supply, valid code, no fault.
// - Dropping logic enable clears faults and rearms soft-start.
// - An undriven logic enable reads as high.
// - Six code inputs form the reference code; undriven bits read high.
// - Strap phase three/four high selects two, three or one phase.
// - No strap selects four phases.
// - Power-ok held low from enable until soft-start completes.
// - After soft-start, undervoltage pulls power-ok low again.
// - Overvoltage drives the crowbar high and latches it.
// - Crowbar drives low only while supply is above 2V.
// - Soft-start ramps the reference from zero to the code.
// - Soft-start selects the higher overvoltage limit mode for the comparator.
`default_nettype none
module rgefc_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Analog comparator levels
    input wire logic supplyDetect,
    input wire logic enAboveOn,
    input wire logic enAboveReset,
    input wire logic overvoltageTrip,
    input wire logic undervoltageTrip,
    input wire logic supplyAbove2V,
    // Logic enable pin and its driven sense
    input wire logic logic_level_enable,
    input wire logic logicEnableDriven,
    // Voltage code pins and their driven sense
    input wire logic [5:0] voltage_id_code,
    input wire logic [5:0] voltageIdDriven,
    // Phase pins, input side sampled as straps
    input wire logic phase_three_output_in,
    input wire logic phase_four_output_in,
    output logic phase_three_output_out,
    output logic phase_three_output_oe,
    output logic phase_four_output_out,
    output logic phase_four_output_oe,
    // Power-ok open-drain pin
    output logic power_ok_flag_out,
    output logic power_ok_flag_oe,
    // Crowbar pin
    output logic overvoltage_crowbar_out,
    output logic overvoltage_crowbar_oe,
    // Reference and status
    output logic [5:0] reference_level,
    output logic ovLimitSoftStart,
    output logic controllerActive,
    output logic [2:0] activePhases
);
    rgefc_sync_if syIf ();
    rgefc_pkg::rgefc_state_t state_q;
    logic [rgefc_pkg::SYNC_W-1:0] cl;
    logic supplyOk, logicEn, vidValid, permit, clearFaults;
    logic [5:0] vidCode;
    logic enOn_q, ovFault_q, uvSeen_q;
    logic [7:0] stepCnt_q;
    logic [5:0] ref_q;
    logic [2:0] phases_q;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    assign syIf.raw = {voltageIdDriven, voltage_id_code, phase_four_output_in, phase_three_output_in,
        supplyAbove2V, undervoltageTrip, overvoltageTrip, logicEnableDriven, logic_level_enable,
        enAboveReset, enAboveOn, supplyDetect};

    rgefc_sync u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .sy(syIf.syncer)
    );

    assign cl = syIf.clean;

    // ------------------------------------------------------------
    // Enable qualification
    // ------------------------------------------------------------
    assign supplyOk = cl[rgefc_pkg::SY_SUPPLY];
    assign logicEn = cl[rgefc_pkg::SY_LEN] | ~cl[rgefc_pkg::SY_LEN_DRV];
    assign vidCode = cl[rgefc_pkg::SY_VID +: 6] | ~cl[rgefc_pkg::SY_VID_DRV +: 6];
    assign vidValid = vidCode != rgefc_pkg::VID_INVALID;
    assign clearFaults = ~cl[rgefc_pkg::SY_EN_HOLD] | ~logicEn | ~supplyOk;
    assign permit = supplyOk & enOn_q & logicEn & vidValid & ~ovFault_q;

    // Threshold enable with hysteresis between on and fault reset levels.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            enOn_q <= 1'b0;
        end else if (cl[rgefc_pkg::SY_EN_ON]) begin
            enOn_q <= 1'b1;
        end else if (!cl[rgefc_pkg::SY_EN_HOLD]) begin
            enOn_q <= 1'b0;
        end
    end

    // Overvoltage latch; a trip in the same cycle as a clear wins.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ovFault_q <= 1'b0;
        end else if (cl[rgefc_pkg::SY_OV] && supplyOk) begin
            ovFault_q <= 1'b1;
        end else if (clearFaults) begin
            ovFault_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Controller state and soft-start ramp
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= rgefc_pkg::ST_OFF;
        end else if (!supplyOk) begin
            state_q <= rgefc_pkg::ST_OFF;
        end else if (!permit) begin
            state_q <= rgefc_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                rgefc_pkg::ST_OFF: begin
                    state_q <= rgefc_pkg::ST_IDLE;
                end
                rgefc_pkg::ST_IDLE: begin
                    state_q <= rgefc_pkg::ST_SOFT;
                end
                rgefc_pkg::ST_SOFT: begin
                    if (ref_q == vidCode) begin
                        state_q <= rgefc_pkg::ST_RUN;
                    end
                end
                rgefc_pkg::ST_RUN: begin
                    state_q <= rgefc_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Reference steps once per step interval during soft-start, then tracks the code.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ref_q <= rgefc_pkg::REF_RESET;
            stepCnt_q <= 8'h00;
        end else if (state_q == rgefc_pkg::ST_SOFT) begin
            if (stepCnt_q == rgefc_pkg::SS_STEP_LAST) begin
                stepCnt_q <= 8'h00;
                if (ref_q < vidCode) begin
                    ref_q <= ref_q + 6'h01;
                end else if (ref_q > vidCode) begin
                    ref_q <= ref_q - 6'h01;
                end
            end else begin
                stepCnt_q <= stepCnt_q + 8'h01;
            end
        end else if (state_q == rgefc_pkg::ST_RUN) begin
            ref_q <= vidCode;
            stepCnt_q <= 8'h00;
        end else begin
            ref_q <= rgefc_pkg::REF_RESET;
            stepCnt_q <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Phase strap decode
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phases_q <= rgefc_pkg::PHASES_FOUR;
        end else if (state_q == rgefc_pkg::ST_OFF || state_q == rgefc_pkg::ST_IDLE) begin
            unique case ({cl[rgefc_pkg::SY_PH4], cl[rgefc_pkg::SY_PH3]})
                2'b01: phases_q <= rgefc_pkg::PHASES_TWO;
                2'b10: phases_q <= rgefc_pkg::PHASES_THREE;
                2'b11: phases_q <= rgefc_pkg::PHASES_ONE;
                2'b00: phases_q <= rgefc_pkg::PHASES_FOUR;
            endcase
        end
    end

    // Strap pins are driven low only when their channel is in use and the block is in soft-start or run with all permits.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase_three_output_oe <= 1'b0;
            phase_four_output_oe <= 1'b0;
        end else begin
            phase_three_output_oe <= permit && (state_q != rgefc_pkg::ST_OFF) && (state_q != rgefc_pkg::ST_IDLE)
                && (phases_q >= rgefc_pkg::PHASES_THREE);
            phase_four_output_oe <= permit && (state_q != rgefc_pkg::ST_OFF) && (state_q != rgefc_pkg::ST_IDLE)
                && (phases_q == rgefc_pkg::PHASES_FOUR);
        end
    end

    // ------------------------------------------------------------
    // Power-ok and crowbar outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            uvSeen_q <= 1'b0;
        end else if (state_q == rgefc_pkg::ST_RUN && cl[rgefc_pkg::SY_UV]) begin
            uvSeen_q <= 1'b1;
        end else if (state_q != rgefc_pkg::ST_RUN) begin
            uvSeen_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            power_ok_flag_oe <= 1'b1;
        end else begin
            power_ok_flag_oe <= !(state_q == rgefc_pkg::ST_RUN && !uvSeen_q && !cl[rgefc_pkg::SY_UV]);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            overvoltage_crowbar_out <= 1'b0;
            overvoltage_crowbar_oe <= 1'b0;
        end else begin
            overvoltage_crowbar_out <= ovFault_q;
            overvoltage_crowbar_oe <= ovFault_q | cl[rgefc_pkg::SY_ABOVE2V];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reference_level <= rgefc_pkg::REF_RESET;
            ovLimitSoftStart <= 1'b1;
            controllerActive <= 1'b0;
            activePhases <= rgefc_pkg::PHASES_FOUR;
        end else begin
            reference_level <= ref_q;
            ovLimitSoftStart <= state_q != rgefc_pkg::ST_RUN;
            controllerActive <= state_q == rgefc_pkg::ST_SOFT || state_q == rgefc_pkg::ST_RUN;
            activePhases <= phases_q;
        end
    end

    assign phase_three_output_out = 1'b0;
    assign phase_four_output_out = 1'b0;
    assign power_ok_flag_out = 1'b0;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence seqSoftDone;
        state_q == rgefc_pkg::ST_SOFT ##1 state_q == rgefc_pkg::ST_RUN;
    endsequence

    a_supply_off_state: assert property (!supplyOk |=> state_q == rgefc_pkg::ST_OFF)
        else $error("State not off after supply loss.");
    a_en_on_sets: assert property (cl[rgefc_pkg::SY_EN_ON] |=> enOn_q)
        else $error("Threshold enable not taken.");
    a_en_reset_clears: assert property (!cl[rgefc_pkg::SY_EN_HOLD] && !cl[rgefc_pkg::SY_OV]
        |=> !ovFault_q && !enOn_q)
        else $error("Fault not cleared by threshold enable drop.");
    a_active_needs_permit: assert property (!permit && supplyOk |=> state_q == rgefc_pkg::ST_IDLE)
        else $error("Active without all permits.");
    a_len_clears_fault: assert property (!logicEn && !cl[rgefc_pkg::SY_OV] |=> !ovFault_q)
        else $error("Logic enable drop did not clear fault.");
    a_len_float_high: assert property (!cl[rgefc_pkg::SY_LEN_DRV] |-> logicEn)
        else $error("Undriven logic enable not high.");
    a_vid_float_high: assert property (&(vidCode | cl[rgefc_pkg::SY_VID_DRV +: 6])
        && ((vidCode ^ cl[rgefc_pkg::SY_VID +: 6]) & cl[rgefc_pkg::SY_VID_DRV +: 6]) == 6'h00)
        else $error("Undriven code bit not high.");
    a_strap_one_phase: assert property (state_q == rgefc_pkg::ST_IDLE && cl[rgefc_pkg::SY_PH3]
        && cl[rgefc_pkg::SY_PH4] |=> phases_q == rgefc_pkg::PHASES_ONE)
        else $error("Both straps did not select one phase.");
    a_strap_four_phase: assert property (state_q == rgefc_pkg::ST_IDLE && !cl[rgefc_pkg::SY_PH3]
        && !cl[rgefc_pkg::SY_PH4] |=> phases_q == rgefc_pkg::PHASES_FOUR)
        else $error("No strap did not select four phases.");
    a_pok_low_soft: assert property (state_q == rgefc_pkg::ST_SOFT |=> power_ok_flag_oe)
        else $error("Power-ok released during soft-start.");
    a_pok_release: assert property (seqSoftDone ##0 (!cl[rgefc_pkg::SY_UV] && permit && !uvSeen_q)
        |=> !power_ok_flag_oe)
        else $error("Power-ok not released after soft-start.");
    a_pok_uv_low: assert property (state_q == rgefc_pkg::ST_RUN && cl[rgefc_pkg::SY_UV]
        |=> power_ok_flag_oe [*2])
        else $error("Undervoltage did not pull power-ok low.");
    a_crowbar_latch: assert property (cl[rgefc_pkg::SY_OV] && supplyOk |=> ##1 overvoltage_crowbar_out
        && overvoltage_crowbar_oe)
        else $error("Crowbar not driven after overvoltage.");
    a_crowbar_no_low: assert property (!ovFault_q && !cl[rgefc_pkg::SY_ABOVE2V] |=> !overvoltage_crowbar_oe)
        else $error("Crowbar pulled low below 2V.");
    a_ramp_from_zero: assert property (state_q == rgefc_pkg::ST_IDLE |=> ref_q == rgefc_pkg::REF_RESET)
        else $error("Reference not reset before soft-start.");
    a_ov_limit_mode: assert property (state_q == rgefc_pkg::ST_SOFT |=> ovLimitSoftStart)
        else $error("Soft-start limit mode not selected.");
    a_fault_blocks: assert property (ovFault_q |=> state_q != rgefc_pkg::ST_SOFT && state_q != rgefc_pkg::ST_RUN)
        else $error("Active while overvoltage latched.");
endmodule
`default_nettype wire

// ---- hdl/rgefc_sync.sv ----
// Three-stage synchroniser that accepts a change once the last two stages agree.
`default_nettype none
module rgefc_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Levels
    rgefc_sync_if.syncer sy
);
    logic [rgefc_pkg::SYNC_W-1:0] s1_q;
    logic [rgefc_pkg::SYNC_W-1:0] s2_q;
    logic [rgefc_pkg::SYNC_W-1:0] s3_q;
    logic [rgefc_pkg::SYNC_W-1:0] clean_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= sy.raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Each bit moves only where the second and third stages agree.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clean_q <= '0;
        end else begin
            clean_q <= (s2_q & s3_q) | (clean_q & (s2_q ^ s3_q));
        end
    end

    assign sy.clean = clean_q;
endmodule
`default_nettype wire

// ---- pkg/rgefc_pkg.sv ----
// Constants, states and field positions shared by the regulator enable and fault logic.
`default_nettype none
package rgefc_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int SS_STEP_NS = 1000;
    localparam int SS_STEP_CYC = (SS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SS_STEP_LAST = 8'(SS_STEP_CYC - 1);
    // ------------------------------------------------------------
    // Widths and codes
    // ------------------------------------------------------------
    localparam int VID_W = 6;
    localparam logic [5:0] VID_INVALID = 6'h3f;
    localparam logic [5:0] REF_RESET = 6'h00;
    localparam logic [2:0] PHASES_ONE = 3'h1;
    localparam logic [2:0] PHASES_TWO = 3'h2;
    localparam logic [2:0] PHASES_THREE = 3'h3;
    localparam logic [2:0] PHASES_FOUR = 3'h4;
    // ------------------------------------------------------------
    // Positions in the synchronised input vector
    // ------------------------------------------------------------
    localparam int SY_SUPPLY = 0;
    localparam int SY_EN_ON = 1;
    localparam int SY_EN_HOLD = 2;
    localparam int SY_LEN = 3;
    localparam int SY_LEN_DRV = 4;
    localparam int SY_OV = 5;
    localparam int SY_UV = 6;
    localparam int SY_ABOVE2V = 7;
    localparam int SY_PH3 = 8;
    localparam int SY_PH4 = 9;
    localparam int SY_VID = 10;
    localparam int SY_VID_DRV = 16;
    localparam int SYNC_W = 22;
    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_IDLE = 2'b01,
        ST_SOFT = 2'b10,
        ST_RUN = 2'b11
    } rgefc_state_t;
endpackage
`default_nettype wire

// ---- pkg/rgefc_sync_if.sv ----
// Interface carrying raw pin levels into the synchroniser and clean levels back.
`default_nettype none
interface rgefc_sync_if;
    logic [rgefc_pkg::SYNC_W-1:0] raw;
    logic [rgefc_pkg::SYNC_W-1:0] clean;
    modport syncer (input raw, output clean);
    modport user (output raw, input clean);
endinterface
`default_nettype wire

// ---- tb/rgefc_far_model.sv ----
// Far-side model: phase straps, power-ok pull-up and crowbar gate load.
`default_nettype none
module rgefc_far_model (
    // Strap choices
    input wire logic tieThree,
    input wire logic tieFour,
    // Device pin drivers
    input wire logic threeOut,
    input wire logic threeOe,
    input wire logic fourOut,
    input wire logic fourOe,
    input wire logic pokOut,
    input wire logic pokOe,
    input wire logic crowOut,
    input wire logic crowOe,
    // Resolved pin levels
    output logic threePin,
    output logic fourPin,
    output logic pokPin,
    output logic crowPin
);
    timeunit 1ns;
    timeprecision 1ns;
    // An undriven phase pin takes the level of its strap choice.
    assign threePin = threeOe ? threeOut : tieThree;
    assign fourPin = fourOe ? fourOut : tieFour;
    // The power-ok line has an external pull-up.
    assign pokPin = pokOe ? pokOut : 1'b1;
    // The crowbar gate has an external pull-down.
    assign crowPin = crowOe ? crowOut : 1'b0;
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench for the regulator enable and fault control.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int sel; logic [5:0] val;} rgefc_note_t;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic sup = 1'b0;
    logic enOn = 1'b0;
    logic enRst = 1'b0;
    logic ovT = 1'b0;
    logic uvT = 1'b0;
    logic above2 = 1'b0;
    logic len = 1'b1;
    logic lenDrv = 1'b1;
    logic [5:0] vid = 6'h02;
    logic [5:0] vidDrv = 6'h3f;
    logic tie3 = 1'b0;
    logic tie4 = 1'b0;
    logic th3Pin, fo4Pin, th3Out, th3Oe, fo4Out, fo4Oe;
    logic pokOut, pokOe, pokPin, crowOut, crowOe, crowPin, ovSoft, active;
    logic [5:0] refLvl;
    logic [5:0] code;
    logic [5:0] got;
    logic [2:0] phases;
    logic [2:0] strapPh [4] = '{3'h4, 3'h2, 3'h3, 3'h1};
    int mismatches = 0;
    int numChecks = 0;
    int seed = 87;
    rgefc_note_t notes[$];
    rgefc_note_t cur;

    always #(rgefc_pkg::CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

    rgefc_ctrl dut_u (.clk_sys(clk_sys), .nrst(nrst), .supplyDetect(sup), .enAboveOn(enOn),
        .enAboveReset(enRst), .overvoltageTrip(ovT), .undervoltageTrip(uvT), .supplyAbove2V(above2),
        .logic_level_enable(len), .logicEnableDriven(lenDrv), .voltage_id_code(vid),
        .voltageIdDriven(vidDrv), .phase_three_output_in(th3Pin), .phase_four_output_in(fo4Pin),
        .phase_three_output_out(th3Out), .phase_three_output_oe(th3Oe), .phase_four_output_out(fo4Out),
        .phase_four_output_oe(fo4Oe), .power_ok_flag_out(pokOut), .power_ok_flag_oe(pokOe),
        .overvoltage_crowbar_out(crowOut), .overvoltage_crowbar_oe(crowOe), .reference_level(refLvl),
        .ovLimitSoftStart(ovSoft), .controllerActive(active), .activePhases(phases));

    rgefc_far_model far_u (.tieThree(tie3), .tieFour(tie4), .threeOut(th3Out), .threeOe(th3Oe),
        .fourOut(fo4Out), .fourOe(fo4Oe), .pokOut(pokOut), .pokOe(pokOe), .crowOut(crowOut),
        .crowOe(crowOe), .threePin(th3Pin), .fourPin(fo4Pin), .pokPin(pokPin), .crowPin(crowPin));

    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        #1;
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            case (cur.sel)
                0: got = {5'h00, active};
                1: got = {5'h00, pokPin};
                2: got = {5'h00, crowPin};
                3: got = {5'h00, crowOe};
                4: got = refLvl;
                5: got = {3'h0, phases};
                6: got = {5'h00, ovSoft};
                default: got = {4'h0, th3Oe, fo4Oe};
            endcase
            numChecks++;
            if (got !== cur.val) begin
                mismatches++;
                $display("[FAIL] %0t output %0d is %h, expected %h", $time, cur.sel, got, cur.val);
            end
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic note_exp(input int sel, input logic [5:0] val);
        rgefc_note_t n;
        n.sel = sel;
        n.val = val;
        notes.push_back(n);
    endtask

    task automatic close_out;
        if (mismatches == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic start_up(input logic [5:0] c);
        vid = c;
        sup = 1'b1;
        enOn = 1'b1;
        enRst = 1'b1;
        cyc(8);
        note_exp(0, 6'h01);
        note_exp(4, 6'h00);
        note_exp(1, 6'h00);
        note_exp(6, 6'h01);
        note_exp(7, 6'h03);
        cyc(int'(c) * rgefc_pkg::SS_STEP_CYC + 12);
        note_exp(4, c);
        note_exp(1, 6'h01);
        note_exp(6, 6'h00);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(19);
        note_exp(0, 6'h00);
        note_exp(1, 6'h00);
        note_exp(3, 6'h00);
        note_exp(4, 6'h00);
        note_exp(5, 6'h04);
        note_exp(6, 6'h01);
        note_exp(7, 6'h00);
        cyc(1);
        nrst = 1'b1;
        above2 = 1'b1;
        cyc(8);
        note_exp(3, 6'h01);
        above2 = 1'b0;
        cyc(8);
        note_exp(3, 6'h00);
        above2 = 1'b1;
        for (int i = 0; i < 4; i++) begin
            {tie4, tie3} = 2'(i);
            cyc(8);
            note_exp(5, {3'h0, strapPh[i]});
        end
        {tie4, tie3} = 2'b00;
        code = 6'h02 + 6'($unsigned($random(seed)) % 3);
        start_up(code);
        uvT = 1'b1;
        cyc(8);
        note_exp(1, 6'h00);
        uvT = 1'b0;
        ovT = 1'b1;
        cyc(8);
        note_exp(2, 6'h01);
        note_exp(3, 6'h01);
        note_exp(7, 6'h00);
        note_exp(0, 6'h00);
        ovT = 1'b0;
        cyc(8);
        note_exp(2, 6'h01);
        note_exp(0, 6'h00);
        enOn = 1'b0;
        enRst = 1'b0;
        cyc(8);
        note_exp(2, 6'h00);
        start_up(code);
        ovT = 1'b1;
        cyc(8);
        ovT = 1'b0;
        len = 1'b0;
        cyc(8);
        note_exp(2, 6'h00);
        note_exp(0, 6'h00);
        lenDrv = 1'b0;
        cyc(8);
        note_exp(0, 6'h01);
        vid = 6'h00;
        vidDrv = 6'h00;
        cyc(8);
        note_exp(0, 6'h00);
        vidDrv = 6'h3e;
        cyc(8);
        note_exp(0, 6'h01);
        cyc(rgefc_pkg::SS_STEP_CYC + 12);
        note_exp(4, 6'h01);
        ovT = 1'b1;
        cyc(8);
        ovT = 1'b0;
        sup = 1'b0;
        cyc(8);
        note_exp(0, 6'h00);
        note_exp(2, 6'h00);
        note_exp(1, 6'h00);
        cyc(2);
        close_out();
    end

    initial begin
        cyc(4000);
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
